// File: hw/slm_lane_mapper.sv
// Lane mapper: transmit FIFO, lane permutation, polarity, loopback and register slave

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides
module slm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // State
  output logic full,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshakes
  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (count == '0);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage, no reset needed
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module slm_lane_mapper (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Transmit stream, one bit per logical lane per word
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Receive stream, one word per cycle
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Serial lane pins
  output logic [7:0] tx_lane,
  input wire logic [7:0] rx_lane,
  // Clocking and port control toward the quads
  output logic [7:0] lane_pll_sel,
  output logic [15:0] lane_freq,
  output logic [7:0] lane_oversample,
  output logic [1:0] port_mode,
  output logic port_wrapper_reset
);
  slm_pkg::slm_lane_cfg_s cfg;
  logic llb_en;
  logic rlb_req;
  logic [1:0] mode;
  logic [1:0] pri_freq;
  logic [1:0] sec_freq;
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic [$clog2(slm_pkg::PW_RST_CYC+1)-1:0] pw_cnt;
  logic pw_trigger;
  logic remap_active;
  logic rlb_active;
  logic [7:0] rx_m1;
  logic [7:0] rx_m2;
  logic [7:0] rx_src;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic f_full;
  logic f_empty;

  // Gather: output lane j takes source lane map[j]
  function automatic logic [7:0] permute(input logic [7:0] src, input logic [23:0] map);
    logic [7:0] r;
    r = '0;
    for (int j = 0; j < slm_pkg::LANES; j++) begin
      r[j] = src[map[3*j +: 3]];
    end
    return r;
  endfunction

  // Merge a write word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register word at the write address, merged under the write strobes
  always_comb begin
    cur_word = '0;
    wr_hit = 1'b1;
    case (aw_addr)
      slm_pkg::ADDR_CTRL: cur_word = {28'h0000000, mode, rlb_req, llb_en};
      slm_pkg::ADDR_PLL_FREQ: cur_word = {28'h0000000, sec_freq, pri_freq};
      slm_pkg::ADDR_PLL_SEL: cur_word = {24'h000000, cfg.pll_sel};
      slm_pkg::ADDR_POL: cur_word = {16'h0000, cfg.rx_inv, cfg.tx_inv};
      slm_pkg::ADDR_TX_MAP: cur_word = {8'h00, cfg.tx_map};
      slm_pkg::ADDR_RX_MAP: cur_word = {8'h00, cfg.rx_map};
      default: wr_hit = 1'b0;
    endcase
  end
  assign new_word = merge(cur_word, w_data, w_strb);

  // Read mux, status included
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      slm_pkg::ADDR_CTRL: rd_word = {28'h0000000, mode, rlb_req, llb_en};
      slm_pkg::ADDR_PLL_FREQ: rd_word = {28'h0000000, sec_freq, pri_freq};
      slm_pkg::ADDR_PLL_SEL: rd_word = {24'h000000, cfg.pll_sel};
      slm_pkg::ADDR_POL: rd_word = {16'h0000, cfg.rx_inv, cfg.tx_inv};
      slm_pkg::ADDR_TX_MAP: rd_word = {8'h00, cfg.tx_map};
      slm_pkg::ADDR_RX_MAP: rd_word = {8'h00, cfg.rx_map};
      slm_pkg::ADDR_STATUS: begin
        rd_word[slm_pkg::ST_REMAP] = remap_active;
        rd_word[slm_pkg::ST_RLB_REFUSED] = rlb_req && remap_active;
        rd_word[slm_pkg::ST_PW_RST] = port_wrapper_reset;
        rd_word[slm_pkg::ST_FULL] = f_full;
        rd_word[slm_pkg::ST_EMPTY] = f_empty;
        rd_word[slm_pkg::ST_OS +: 8] = lane_oversample;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channels held independently; either may arrive first
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only address answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= slm_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? slm_pkg::RESP_OKAY : slm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, one outstanding read
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= slm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? slm_pkg::RESP_OKAY : slm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, defaults give a transparent core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      llb_en <= 1'b0;
      rlb_req <= 1'b0;
      mode <= slm_pkg::MODE_X1;
      pri_freq <= slm_pkg::FREQ_RESET[1:0];
      sec_freq <= slm_pkg::FREQ_RESET[3:2];
      cfg.pll_sel <= '0;
      cfg.tx_inv <= '0;
      cfg.rx_inv <= '0;
      cfg.tx_map <= slm_pkg::MAP_IDENTITY;
      cfg.rx_map <= slm_pkg::MAP_IDENTITY;
    end else if (do_write && wr_hit) begin
      case (aw_addr)
        slm_pkg::ADDR_CTRL: begin
          llb_en <= new_word[slm_pkg::CTRL_LLB];
          rlb_req <= new_word[slm_pkg::CTRL_RLB];
          mode <= new_word[slm_pkg::CTRL_MODE +: 2];
        end
        slm_pkg::ADDR_PLL_FREQ: begin
          pri_freq <= new_word[slm_pkg::FREQ_PRI +: 2];
          sec_freq <= new_word[slm_pkg::FREQ_SEC +: 2];
        end
        slm_pkg::ADDR_PLL_SEL: cfg.pll_sel <= new_word[7:0];
        slm_pkg::ADDR_POL: begin
          cfg.tx_inv <= new_word[7:0];
          cfg.rx_inv <= new_word[slm_pkg::POL_RX +: 8];
        end
        slm_pkg::ADDR_TX_MAP: cfg.tx_map <= new_word[23:0];
        slm_pkg::ADDR_RX_MAP: cfg.rx_map <= new_word[23:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only a primary rate change or a regrouping of ports needs a wrapper reset
  assign pw_trigger = do_write && ((aw_addr == slm_pkg::ADDR_PLL_FREQ
                      && new_word[slm_pkg::FREQ_PRI +: 2] != pri_freq)
                      || (aw_addr == slm_pkg::ADDR_CTRL
                      && new_word[slm_pkg::CTRL_MODE +: 2] != mode));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_cnt <= '0;
    end else if (pw_trigger) begin
      pw_cnt <= ($bits(pw_cnt))'(slm_pkg::PW_RST_CYC);
    end else if (pw_cnt != '0) begin
      pw_cnt <= pw_cnt - 1'b1;
    end
  end
  assign port_wrapper_reset = (pw_cnt != '0);

  // Per-lane clock source and rate; 20.6250G lanes carry 10.3125G at 2x
  always_comb begin
    for (int i = 0; i < slm_pkg::LANES; i++) begin
      lane_freq[2*i +: 2] = cfg.pll_sel[i] ? sec_freq : pri_freq;
      lane_oversample[i] = (lane_freq[2*i +: 2] == slm_pkg::F_20G625);
    end
  end
  assign lane_pll_sel = cfg.pll_sel;
  // Groups of 1/2/4/8 always start on a lane multiple, so stay in this core
  assign port_mode = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Remote loopback stays off while any map is non-identity; the request waits for identity maps
  assign remap_active = (cfg.tx_map != slm_pkg::MAP_IDENTITY)
                        || (cfg.rx_map != slm_pkg::MAP_IDENTITY);
  assign rlb_active = rlb_req && !remap_active;

  // Transmit buffer; drain stalls during the wrapper reset
  slm_fifo #(
    .WIDTH(slm_pkg::LANES),
    .DEPTH(slm_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .full(f_full),
    .empty(f_empty)
  );
  assign f_ready = !port_wrapper_reset && !rlb_active;

  // Receive pins cross into aclk through two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_m1 <= '0;
      rx_m2 <= '0;
    end else begin
      rx_m1 <= rx_lane;
      rx_m2 <= rx_m1;
    end
  end

  // Transmit pins: remote loopback echoes receive pins, else mapped data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_lane <= '0;
    end else if (rlb_active) begin
      tx_lane <= rx_m2;
    end else if (f_valid && f_ready) begin
      tx_lane <= permute(f_data, cfg.tx_map) ^ cfg.tx_inv;
    end else begin
      tx_lane <= '0;
    end
  end

  // Local loopback turns transmit pins back; no coding-layer path exists
  assign rx_src = llb_en ? tx_lane : rx_m2;

  // Receive runs every cycle regardless of transmit activity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_valid <= 1'b1;
      rx_data <= permute(rx_src ^ cfg.rx_inv, cfg.rx_map);
    end
  end
endmodule

// File: hw/slm_pkg.sv
// Package: register map, field layout, reset values and timing for the lane mapper
package slm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PLL_FREQ = 8'h04;
  localparam logic [7:0] ADDR_PLL_SEL = 8'h08;
  localparam logic [7:0] ADDR_POL = 8'h0c;
  localparam logic [7:0] ADDR_TX_MAP = 8'h10;
  localparam logic [7:0] ADDR_RX_MAP = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Field positions
  localparam int CTRL_LLB = 0;
  localparam int CTRL_RLB = 1;
  localparam int CTRL_MODE = 2;
  localparam int FREQ_PRI = 0;
  localparam int FREQ_SEC = 2;
  localparam int POL_RX = 8;
  localparam int ST_REMAP = 0;
  localparam int ST_RLB_REFUSED = 1;
  localparam int ST_PW_RST = 2;
  localparam int ST_FULL = 3;
  localparam int ST_EMPTY = 4;
  localparam int ST_OS = 8;
  // Lane and buffer geometry
  localparam int LANES = 8;
  localparam int FIFO_DEPTH = 32;
  // PLL frequency codes: 20.6250G, 25.78125G, 26.5625G
  localparam logic [1:0] F_20G625 = 2'h0;
  localparam logic [1:0] F_25G78125 = 2'h1;
  localparam logic [1:0] F_26G5625 = 2'h2;
  // Port width codes: 1, 2, 4 or 8 lanes per port
  localparam logic [1:0] MODE_X1 = 2'h0;
  // Reset values and bus response codes
  localparam logic [23:0] MAP_IDENTITY = 24'hfac688;
  localparam logic [3:0] FREQ_RESET = 4'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Port wrapper reset time
  localparam int CLK_PERIOD_NS = 50;
  localparam int PW_RST_NS = 1000;
  localparam int PW_RST_CYC = (PW_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Lane configuration carried as one bundle
  typedef struct packed {
    logic [7:0] pll_sel;
    logic [7:0] tx_inv;
    logic [7:0] rx_inv;
    logic [23:0] tx_map;
    logic [23:0] rx_map;
  } slm_lane_cfg_s;
endpackage

// File: test/slm_lane_mapper_checker.sv
// Checker: bus handshakes and lane configuration outputs of the lane mapper
module slm_lane_mapper_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Lanes and configuration
  input wire logic rx_valid,
  input wire logic [7:0] tx_lane,
  input wire logic [7:0] lane_pll_sel,
  input wire logic [15:0] lane_freq,
  input wire logic [7:0] lane_oversample,
  input wire logic port_wrapper_reset
);
  logic [7:0] os_exp;
  logic [9:0] pw_run;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////
  // Oversampling expected on every lane running the lowest rate code
  always_comb begin
    for (int j = 0; j < 8; j++) begin
      os_exp[j] = lane_freq[2*j+:2] == slm_pkg::F_20G625;
    end
  end

  // Length of the current wrapper reset pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || !port_wrapper_reset) begin
      pw_run <= 10'h000;
    end else begin
      pw_run <= pw_run + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  os_follows_rate_a:
    assert property (lane_oversample == os_exp) else $error("oversample flags off");
  pw_pulse_len_a:
    assert property ($fell(port_wrapper_reset) && $past(aresetn) |-> pw_run >= 10'd20)
    else $error("wrapper reset pulse too short");
  reset_defaults_a:
    assert property ($rose(aresetn) |-> lane_pll_sel == 8'h00 && lane_freq == 16'h5555
      && !port_wrapper_reset && tx_lane == 8'h00) else $error("bad reset state");
  rx_always_on_a:
    assert property ($past(aresetn) |-> rx_valid) else $error("receive path stopped");
  pll_sel_quiet_a:
    assert property (!s_axi_wvalid && !$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
      |-> $stable(lane_pll_sel)) else $error("PLL select moved without a write");
  wr_resp_lat_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
  bresp_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rd_lat_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  one_read_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");

  // Main scenarios reached
  cover property ($fell(port_wrapper_reset));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind slm_lane_mapper slm_lane_mapper_checker i_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .rx_valid, .tx_lane,
  .lane_pll_sel, .lane_freq, .lane_oversample, .port_wrapper_reset);

// File: test/slm_link_partner.sv
// Link partner: serial transmitter facing all eight lanes; its tx_lane input is unused
module slm_link_partner (
  // Clock
  input wire logic aclk,
  // Lanes
  input wire logic [7:0] tx_lane,
  output logic [7:0] rx_lane,
  // Bench control
  input wire logic [7:0] pattern,
  input wire logic hold
);
  timeunit 1ns;
  timeprecision 1ps;

  // One partner per eight-lane core, speeds kept compatible by the bench
  // Sends every cycle whatever the core does; a released line toggles so no stale level lingers
  initial rx_lane = 8'h00;
  always @(posedge aclk) begin
    rx_lane <= hold ? pattern : ~rx_lane;
  end
endmodule

// File: test/testbench.sv
// Testbench: registers, wrapper reset, lane mapping, buffer and loopbacks
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, tx_valid, tx_ready, rx_valid, port_wrapper_reset, hold, mon_on, llb_on, slow;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tx_data, rx_data, tx_lane, rx_lane, lane_pll_sel;
  logic [7:0] lane_oversample, pattern, tv, rv, ps, prev_tx;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, port_mode, r;
  logic [3:0] s_axi_wstrb;
  logic [15:0] lane_freq;
  logic [23:0] tm, rm;
  logic [7:0] exp_q[$];
  int seed = 32'hdedb;
  int miscompares, n_compared, pw_run, pw_last;

  slm_lane_mapper i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_valid, .tx_ready, .tx_data, .rx_valid,
    .rx_data, .tx_lane, .rx_lane, .lane_pll_sel, .lane_freq, .lane_oversample, .port_mode,
    .port_wrapper_reset);
  slm_link_partner i_partner (.aclk, .tx_lane, .rx_lane, .pattern, .hold);

  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Lane j carries source bit m[j] then inversion v[j]
  function automatic logic [7:0] perm(input logic [7:0] s, input logic [23:0] m,
                                      input logic [7:0] v);
    for (int j = 0; j < 8; j++) perm[j] = s[m[3*j+:3]] ^ v[j];
  endfunction

  function automatic logic [23:0] shuf();
    logic [2:0] p [8];
    logic [2:0] t;
    int k;
    for (int j = 0; j < 8; j++) p[j] = 3'(j);
    for (int j = 7; j > 0; j--) begin
      k = $unsigned($random(seed)) % (j + 1);
      t = p[j];
      p[j] = p[k];
      p[k] = t;
    end
    for (int j = 0; j < 8; j++) shuf[3*j+:3] = p[j];
  endfunction

  // Expected {oversample, lane rate codes} for a PLL select word
  function automatic logic [31:0] fexp(input logic [7:0] s, input int p, input int q);
    logic [1:0] f;
    fexp = 32'h0;
    for (int j = 0; j < 8; j++) begin
      f = s[j] ? q[1:0] : p[1:0];
      fexp[2*j+:2] = f;
      fexp[16+j] = f == slm_pkg::F_20G625;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus master: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    do begin
      @(posedge aclk);
      if (pa && s_axi_awready) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    // Late ready: the response must stand until bready is seen
    if (slow) begin
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    rs = s_axi_bresp;
  endtask

  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    wr(a, v, rs);
    chk(rs, slm_pkg::RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    if (slow) begin
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
    end
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  // Random words, flipped if they would leave the lanes all zero (the idle value)
  task automatic send(input int n);
    logic [7:0] w;
    for (int i = 0; i < n; i++) begin
      w = $random(seed);
      if (perm(w, tm, tv) == 8'h00) w = ~w;
      tx_data <= w;
      tx_valid <= 1'b1;
      do @(posedge aclk); while (tx_ready !== 1'b1);
      exp_q.push_back(perm(w, tm, tv));
    end
    tx_valid <= 1'b0;
  endtask

  task automatic drain();
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge aclk);
    chk(exp_q.size(), 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Lane monitor and wrapper reset pulse length, just after each edge
  always @(posedge aclk) begin
    #1;
    if (mon_on && tx_lane !== 8'h00) begin
      chk(tx_lane, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
    end
    if (llb_on) chk(rx_data, prev_tx);
    prev_tx = tx_lane;
    if (port_wrapper_reset === 1'b1) begin
      pw_run++;
    end else if (pw_run > 0) begin
      pw_last = pw_run;
      pw_run = 0;
    end
  end

  // Watchdog: the run needs a few hundred cycles
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, tx_valid, hold, mon_on, llb_on, slow} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, tx_data, pattern, s_axi_wdata} = 64'h0;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(lane_freq, 16'h5555);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d, r);
      chk(d, i == 1 ? 32'(slm_pkg::FREQ_RESET) : (i > 3 ? 32'(slm_pkg::MAP_IDENTITY) : 0));
    end
    rd(8'h1c, d, r);
    chk(d, 32'h0);
    chk(r, slm_pkg::RESP_SLVERR);
    wr(slm_pkg::ADDR_STATUS, 32'hffff, r);
    chk(r, slm_pkg::RESP_SLVERR);
    // Every port width; each change pulses the wrapper reset
    for (int m = 1; m <= 4; m++) begin
      wo(slm_pkg::ADDR_CTRL, 32'(m % 4) << slm_pkg::CTRL_MODE);
      repeat (30) @(posedge aclk);
      chk(port_mode, m % 4);
      chk(pw_last, slm_pkg::PW_RST_CYC);
      pw_last = 0;
    end
    // Each lane picks a PLL; primary change resets the wrapper, secondary does not
    ps = $random(seed);
    wo(slm_pkg::ADDR_PLL_SEL, {24'h0, ps});
    chk(lane_pll_sel, ps);
    for (int c = 0; c < 3; c++) begin
      wo(slm_pkg::ADDR_PLL_FREQ, 32'(((c + 1) % 3) << 2 | c));
      repeat (30) @(posedge aclk);
      chk(pw_last, slm_pkg::PW_RST_CYC);
      chk({lane_oversample, lane_freq}, fexp(ps, c, (c + 1) % 3));
      pw_last = 0;
      wo(slm_pkg::ADDR_PLL_FREQ, 32'(c << 2 | c));
      repeat (30) @(posedge aclk);
      chk(pw_last, 0);
      chk({lane_oversample, lane_freq}, fexp(ps, c, c));
    end
    // Remote loopback stalls the drain: fill the buffer until it refuses
    tm = slm_pkg::MAP_IDENTITY;
    tv = 8'h00;
    pattern <= 8'h5a;
    hold <= 1'b1;
    // Answers taken late here, so the slave has to hold them
    slow = 1'b1;
    wo(slm_pkg::ADDR_CTRL, 32'h2);
    repeat (4) @(posedge aclk);
    chk(tx_lane, 8'h5a);
    send(slm_pkg::FIFO_DEPTH);
    repeat (2) @(posedge aclk);
    chk(tx_ready, 1'b0);
    rd(slm_pkg::ADDR_STATUS, d, r);
    chk(d[slm_pkg::ST_FULL], 1'b1);
    slow = 1'b0;
    pattern <= 8'h00;
    repeat (4) @(posedge aclk);
    mon_on = 1'b1;
    wo(slm_pkg::ADDR_CTRL, 32'h0);
    drain();
    rd(slm_pkg::ADDR_STATUS, d, r);
    chk(d[slm_pkg::ST_EMPTY], 1'b1);
    // Remapped lanes: remote loopback refused, data keeps flowing
    tm = shuf();
    rm = shuf();
    tv = $random(seed);
    rv = $random(seed);
    hold <= 1'b0;
    wo(slm_pkg::ADDR_TX_MAP, {8'h0, tm});
    wo(slm_pkg::ADDR_RX_MAP, {8'h0, rm});
    wo(slm_pkg::ADDR_POL, {16'h0, rv, tv});
    wo(slm_pkg::ADDR_CTRL, 32'h2);
    rd(slm_pkg::ADDR_STATUS, d, r);
    chk({d[slm_pkg::ST_RLB_REFUSED], d[slm_pkg::ST_REMAP]}, 2'h3);
    send(40);
    drain();
    wo(slm_pkg::ADDR_CTRL, 32'h0);
    // Receive lanes un-mapped and inverted on their own side
    hold <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      pattern <= $random(seed);
      repeat (5) @(posedge aclk);
      chk(rx_data, perm(pattern ^ rv, rm, 8'h00));
    end
    // Byte strobes: clear only the receive inversion byte
    s_axi_wstrb <= 4'h2;
    wo(slm_pkg::ADDR_POL, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(slm_pkg::ADDR_POL, d, r);
    chk(d, {24'h0, tv});
    // Local loopback only after every remap is cleared
    tm = slm_pkg::MAP_IDENTITY;
    tv = 8'h00;
    wo(slm_pkg::ADDR_TX_MAP, {8'h0, tm});
    wo(slm_pkg::ADDR_RX_MAP, {8'h0, tm});
    wo(slm_pkg::ADDR_POL, 32'h0);
    wo(slm_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    llb_on = 1'b1;
    send(16);
    drain();
    llb_on = 1'b0;
    summarize();
  end
endmodule
